// ===== src/isa_expansion_params.svh
// constants for the expansion bus cycle controller
// assumes: included by bare name by every design file that needs offsets
`ifndef ISA_EXPANSION_PARAMS_SVH
`define ISA_EXPANSION_PARAMS_SVH
// register indices as printed, byte address four times the index; the last two are byte addresses
`define REG_IDX_CLOCK_GEN_MODE 10'h001
`define REG_IDX_EXP_BUS_MODE   10'h034
`define REG_ADDR_PIN_CONFIG    12'h100
`define REG_ADDR_CYCLE_STATUS  12'h104
// reset values
`define CGM_RESET        8'h22
`define EBM_RESET        8'h00
`define PIN_CONFIG_RESET 6'h00
// field positions
`define BUS_CLOCK_DIVIDER_SELECT_LSB   0
`define BUS_CLOCK_DIVIDER_SELECT_MSB   1
`define OSCILLATOR_DIVIDER_SELECT_LSB 5
`define OSCILLATOR_DIVIDER_SELECT_MSB 6
`define BUS_CLOCK_MODE_SELECT_LSB 6
`define BUS_CLOCK_MODE_SELECT_MSB 7
// divider encodings and resulting divisors
`define BUS_CLOCK_DIVIDER_SELECT_BY4 2'h0
`define BUS_CLOCK_DIVIDER_SELECT_BY3 2'h1
`define BUS_CLOCK_DIVIDER_SELECT_BY2 2'h2
`define DIV_FOUR  3'h4
`define DIV_THREE 3'h3
`define DIV_TWO   3'h2
// longest wait for bus clock phase in sync mode, processor clocks
`define SYNC_WAIT_MAX 4
`endif

// ===== src/isa_expansion_pkg.sv
// types shared by the expansion cycle controller and its helpers
// assumes: nothing beyond a SystemVerilog compiler
package isa_expansion_pkg;
  typedef enum logic [1:0] {
    CLK_STOP = 2'b00, CLK_SYNC = 2'b01, CLK_STRETCH = 2'b10, CLK_RSVD = 2'b11
  } bus_clock_mode_e;
  typedef enum logic [1:0] {
    TGT_RAM = 2'b00, TGT_ROM = 2'b01, TGT_PCCARD = 2'b10, TGT_ISA = 2'b11
  } target_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_ALIGN = 3'b001, ST_ADDR = 3'b010,
    ST_CMD = 3'b011, ST_END = 3'b100
  } cycle_state_e;
  typedef struct packed {
    logic        valid;
    target_e     target;
    logic        is_io;
    logic        write;
    logic        wide;
    logic [19:0] addr;
    logic [15:0] wdata;
  } isa_req_s;
  typedef struct packed {
    logic        done;
    logic [15:0] rdata;
  } isa_rsp_s;
  typedef struct packed {
    logic rom_oe_en;
    logic pccard_gpio_en;
    logic busclk_out_en;
    logic bhe_out_en;
    logic mem_wide_en;
    logic io_wide_en;
  } pin_cfg_s;
  typedef struct packed {
    logic active;
    logic is_io;
    logic is_pccard;
    logic write;
  } cmd_s;
endpackage

// ===== src/bus_clock_gen.sv
// expansion bus clock divider with stop, sync and stretch modes
// assumes: pclk is the processor clock; start_req held until aligned
`timescale 1ns/100ps
`include "isa_expansion_params.svh"
module bus_clock_gen import isa_expansion_pkg::*; (
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // control
  input  wire logic [2:0]      div,
  input  wire bus_clock_mode_e mode,
  input  wire logic            run,
  input  wire logic            start_req,
  // outputs
  output logic                 aligned,
  output logic                 tick,
  output logic                 bus_clk
);
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic       next_clk;
  logic       next_tick;
  logic       wrap;
  logic       active;

  always_comb begin
    // >= recovers at once when the divisor shrinks while counting
    wrap    = (cnt >= div - 3'h1);
    // sync waits for the phase; stop and stretch restart on demand
    aligned = start_req && ((mode != CLK_SYNC) || wrap);
    active  = (mode != CLK_STOP) || run || aligned;
    if (aligned) begin
      next_cnt = 3'h0;
    end else if (!active) begin
      next_cnt = 3'h0;
    end else begin
      next_cnt = wrap ? 3'h0 : cnt + 3'h1;
    end
    // low time is the longer half on an odd divisor
    next_clk  = active && (next_cnt < (div >> 1));
    next_tick = active && (next_cnt == 3'h0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt     <= 3'h0;
      bus_clk <= 1'b0;
      tick    <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      bus_clk <= next_clk;
      tick    <= next_tick;
    end
  end
endmodule // bus_clock_gen

// ===== src/strobe_router.sv
// routes the active command onto dedicated and pc card strobe pins
// assumes: cmd changes only on processor clock edges
`timescale 1ns/100ps
module strobe_router import isa_expansion_pkg::*; (
  // clock and reset
  input  wire logic     pclk,
  input  wire logic     presetn,
  // command source
  input  wire cmd_s     cmd,
  input  wire pin_cfg_s cfg,
  input  wire logic     slot_powered,
  input  wire logic     mc_ram_active,
  input  wire logic     mc_rom_read,
  input  wire logic     rom_chip_enable_zero,
  input  wire logic     rom_chip_enable_one,
  // strobes, active low; pccard_strobe_oe is active high
  output logic          io_read_strobe_n,
  output logic          io_write_strobe_n,
  output logic          mem_read_strobe_n,
  output logic          mem_write_strobe_n,
  output logic          pccard_oe_n,
  output logic          pccard_we_n,
  output logic          pccard_strobe_oe
);
  logic mem_cyc;
  logic card_gpio;
  logic rom_oe;
  logic next_ior, next_iow, next_mr, next_mw, next_cr, next_cw, next_coe;

  always_comb begin
    card_gpio = cmd.is_pccard && cfg.pccard_gpio_en;
    mem_cyc   = cmd.active && !cmd.is_io && !card_gpio && !mc_ram_active;
    rom_oe    = cfg.rom_oe_en && mc_rom_read
                && (rom_chip_enable_zero || rom_chip_enable_one);
    next_ior  = !(cmd.active && cmd.is_io && !cmd.write);
    next_iow  = !(cmd.active && cmd.is_io && cmd.write);
    next_mr   = !((mem_cyc && !cmd.write) || (rom_oe && !mc_ram_active));
    next_mw   = !(mem_cyc && cmd.write);
    next_cr   = !(cmd.active && card_gpio && !cmd.write);
    next_cw   = !(cmd.active && card_gpio && cmd.write);
    // unpowered slot sees no drive at all
    next_coe  = cfg.pccard_gpio_en && slot_powered;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_read_strobe_n   <= 1'b1;
      io_write_strobe_n  <= 1'b1;
      mem_read_strobe_n  <= 1'b1;
      mem_write_strobe_n <= 1'b1;
      pccard_oe_n        <= 1'b1;
      pccard_we_n        <= 1'b1;
      pccard_strobe_oe   <= 1'b0;
    end else begin
      io_read_strobe_n   <= next_ior;
      io_write_strobe_n  <= next_iow;
      mem_read_strobe_n  <= next_mr;
      mem_write_strobe_n <= next_mw;
      pccard_oe_n        <= next_cr;
      pccard_we_n        <= next_cw;
      pccard_strobe_oe   <= next_coe;
    end
  end
endmodule // strobe_router

// ===== src/isa_expansion_cycle_control.sv
// expansion bus cycle controller: apb registers and cycle sequencer
// assumes: pclk is the processor clock; memory controller owns ram/rom
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
`include "isa_expansion_params.svh"
module isa_expansion_cycle_control import isa_expansion_pkg::*; #(
  parameter int CMD_TICKS = 2,
  parameter int PADDR_W   = 12
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // processor request and answer
  input  wire isa_req_s           req,
  output logic                    req_ready,
  output isa_rsp_s                rsp,
  // memory controller status
  input  wire logic               mc_ram_active,
  input  wire logic               mc_rom_read,
  input  wire logic               rom_chip_enable_zero,
  input  wire logic               rom_chip_enable_one,
  // expansion bus address and data
  output logic [19:0]             bus_addr,
  output logic [15:0]             bus_data_out,
  output logic                    bus_data_oe,
  input  wire logic [15:0]        bus_data_in,
  input  wire logic               channel_ready,
  input  wire logic               io_wide_select_n,
  input  wire logic               mem_wide_select_n,
  // command strobes
  output logic                    io_read_strobe_n,
  output logic                    io_write_strobe_n,
  output logic                    mem_read_strobe_n,
  output logic                    mem_write_strobe_n,
  // gpio functions
  output logic                    high_byte_enable_n,
  output logic                    high_byte_enable_oe,
  output logic                    expansion_bus_clock,
  output logic                    bus_clock_gpio_oe,
  input  wire logic               slot_powered,
  output logic                    pccard_oe_n,
  output logic                    pccard_we_n,
  output logic                    pccard_strobe_oe,
  // clock generator control toward the oscillator divider
  output logic [1:0]              oscillator_divider_select
);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (CMD_TICKS < 1 || CMD_TICKS > 7) begin : g_bad_cmd_ticks
    $error("CMD_TICKS must lie between 1 and 7");
  end
  if (PADDR_W < 12) begin : g_bad_paddr_w
    $error("PADDR_W must be at least 12");
  end

  localparam logic [2:0] CMD_LAST = 3'(CMD_TICKS - 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [PADDR_W-1:0] idx_addr(input logic [9:0] idx);
    idx_addr = PADDR_W'({idx, 2'b00});
  endfunction

  function automatic logic [2:0] bus_divisor(input logic [1:0] sel);
    case (sel)
      `BUS_CLOCK_DIVIDER_SELECT_BY4: bus_divisor = `DIV_FOUR;
      `BUS_CLOCK_DIVIDER_SELECT_BY3: bus_divisor = `DIV_THREE;
      `BUS_CLOCK_DIVIDER_SELECT_BY2: bus_divisor = `DIV_TWO;
      default:   bus_divisor = `DIV_TWO; // reserved setting, kept safe
    endcase
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]      clock_generator_mode;
  logic [7:0]      expansion_bus_mode;
  pin_cfg_s        pin_config;
  logic [7:0]      next_cgm;
  logic [7:0]      next_ebm;
  pin_cfg_s        next_pin;
  logic [31:0]     next_prdata;
  logic            next_pslverr;
  logic [31:0]     status_word;
  logic            setup;
  logic            wr_en;
  bus_clock_mode_e bus_clock_mode_select;
  logic [1:0]      bus_clock_divider_select;

  assign bus_clock_divider_select =
    clock_generator_mode[`BUS_CLOCK_DIVIDER_SELECT_MSB:`BUS_CLOCK_DIVIDER_SELECT_LSB];
  assign oscillator_divider_select =
    clock_generator_mode[`OSCILLATOR_DIVIDER_SELECT_MSB:`OSCILLATOR_DIVIDER_SELECT_LSB];
  assign bus_clock_mode_select = bus_clock_mode_e'(
    expansion_bus_mode[`BUS_CLOCK_MODE_SELECT_MSB:`BUS_CLOCK_MODE_SELECT_LSB]);

  assign pready = 1'b1;
  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pwrite;

  always_comb begin
    next_cgm     = clock_generator_mode;
    next_ebm     = expansion_bus_mode;
    next_pin     = pin_config;
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (setup) begin
      next_pslverr = 1'b0;
      next_prdata  = 32'h0000_0000;
      if (paddr == idx_addr(`REG_IDX_CLOCK_GEN_MODE)) begin
        next_prdata = {24'h00_0000, clock_generator_mode};
      end else if (paddr == idx_addr(`REG_IDX_EXP_BUS_MODE)) begin
        next_prdata = {24'h00_0000, expansion_bus_mode};
      end else if (paddr == `REG_ADDR_PIN_CONFIG) begin
        next_prdata = {26'h000_0000, pin_config};
      end else if (paddr == `REG_ADDR_CYCLE_STATUS) begin
        next_prdata = status_word;
      end else begin
        next_pslverr = 1'b1;
      end
    end
    if (wr_en) begin
      if (paddr == idx_addr(`REG_IDX_CLOCK_GEN_MODE)) begin
        next_cgm = pwdata[7:0];
      end else if (paddr == idx_addr(`REG_IDX_EXP_BUS_MODE)) begin
        next_ebm = pwdata[7:0];
      end else if (paddr == `REG_ADDR_PIN_CONFIG) begin
        next_pin = pin_cfg_s'(pwdata[5:0]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_generator_mode <= `CGM_RESET;
      expansion_bus_mode   <= `EBM_RESET;
      pin_config           <= `PIN_CONFIG_RESET;
      prdata               <= 32'h0000_0000;
      pslverr              <= 1'b0;
    end else begin
      clock_generator_mode <= next_cgm;
      expansion_bus_mode   <= next_ebm;
      pin_config           <= next_pin;
      prdata               <= next_prdata;
      pslverr              <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // bus clock
  // ----------------------------------------------------------------
  cycle_state_e state;
  cycle_state_e next_state;
  logic         start_req;
  logic         aligned;
  logic         tick;
  logic         bus_clk;
  logic         run;

  assign start_req = (state == ST_ALIGN);
  assign run       = (state == ST_ADDR) || (state == ST_CMD) || (state == ST_END);

  bus_clock_gen u_clk (
    .pclk      (pclk),
    .presetn   (presetn),
    .div       (bus_divisor(bus_clock_divider_select)),
    .mode      (bus_clock_mode_select),
    .run       (run),
    .start_req (start_req),
    .aligned   (aligned),
    .tick      (tick),
    .bus_clk   (bus_clk)
  );

  assign expansion_bus_clock = bus_clk;
  assign bus_clock_gpio_oe   = pin_config.busclk_out_en;

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  isa_req_s    req_q,      next_req_q;
  logic [2:0]  tcnt,       next_tcnt;
  logic        odd_phase,  next_odd_phase;
  logic        split,      next_split;
  logic        wide_go,    next_wide_go;
  logic [15:0] rdata_q,    next_rdata_q;
  logic        done_q,     next_done_q;
  logic [19:0] next_addr;
  logic [15:0] next_dout;
  logic        next_doe;
  logic        next_bhe_n;
  logic [15:0] cycle_count, next_cycle_count;
  logic        take;
  logic        wide_back;

  // expansion targets only; ram and rom stay with the memory controller
  assign take      = req.valid && (state == ST_IDLE)
                     && (req.target == TGT_ISA || req.target == TGT_PCCARD);
  assign req_ready = (state == ST_IDLE);
  // an input that is not enabled on a gpio never counts as returned
  assign wide_back = req_q.is_io ? (pin_config.io_wide_en && !io_wide_select_n)
                                 : (pin_config.mem_wide_en && !mem_wide_select_n);

  always_comb begin
    next_state       = state;
    next_req_q       = req_q;
    next_tcnt        = tcnt;
    next_odd_phase   = odd_phase;
    next_split       = split;
    next_wide_go     = wide_go;
    next_rdata_q     = rdata_q;
    next_done_q      = 1'b0;
    next_addr        = bus_addr;
    next_dout        = bus_data_out;
    next_doe         = bus_data_oe;
    next_bhe_n       = high_byte_enable_n;
    next_cycle_count = cycle_count;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_req_q     = req;
          next_odd_phase = 1'b0;
          next_split     = 1'b0;
          next_wide_go   = 1'b0;
          next_state     = ST_ALIGN;
        end
      end
      ST_ALIGN: begin
        if (aligned) begin
          next_tcnt  = 3'h0;
          // a split starts on the even byte of the word
          next_addr  = {req_q.addr[19:1], req_q.wide ? 1'b0 : req_q.addr[0]};
          next_bhe_n = !(req_q.wide || req_q.addr[0]);
          next_dout  = req_q.wdata;
          next_doe   = req_q.write;
          next_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (tick) begin
          if (tcnt == 3'h0) begin
            next_tcnt = 3'h1;
          end else begin
            next_tcnt = 3'h0;
            if (req_q.wide && !odd_phase) begin
              next_wide_go = wide_back;
              next_split   = !wide_back;
            end
            next_state = ST_CMD;
          end
        end
      end
      ST_CMD: begin
        if (tick) begin
          if (tcnt >= CMD_LAST && channel_ready) begin
            if (wide_go) begin
              next_rdata_q = bus_data_in;
            end else if (odd_phase) begin
              next_rdata_q = {bus_data_in[7:0], rdata_q[7:0]};
            end else if (req_q.wide) begin
              next_rdata_q = {rdata_q[15:8], bus_data_in[7:0]};
            end else begin
              next_rdata_q = {8'h00, bus_data_in[7:0]};
            end
            next_state = ST_END;
          end else if (tcnt < CMD_LAST) begin
            next_tcnt = tcnt + 3'h1;
          end
        end
      end
      ST_END: begin
        if (tick) begin
          next_tcnt        = 3'h0;
          next_cycle_count = cycle_count + 16'h0001;
          if (split && !odd_phase) begin
            // second byte cycle goes to the odd address, low lane
            next_odd_phase = 1'b1;
            next_addr      = {req_q.addr[19:1], 1'b1};
            next_bhe_n     = 1'b0;
            next_dout      = {req_q.wdata[15:8], req_q.wdata[15:8]};
            next_state     = ST_ADDR;
          end else begin
            next_doe    = 1'b0;
            next_done_q = 1'b1;
            next_state  = ST_IDLE;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state              <= ST_IDLE;
      req_q              <= '0;
      tcnt               <= 3'h0;
      odd_phase          <= 1'b0;
      split              <= 1'b0;
      wide_go            <= 1'b0;
      rdata_q            <= 16'h0000;
      done_q             <= 1'b0;
      bus_addr           <= 20'h0_0000;
      bus_data_out       <= 16'h0000;
      bus_data_oe        <= 1'b0;
      high_byte_enable_n <= 1'b1;
      cycle_count        <= 16'h0000;
    end else begin
      state              <= next_state;
      req_q              <= next_req_q;
      tcnt               <= next_tcnt;
      odd_phase          <= next_odd_phase;
      split              <= next_split;
      wide_go            <= next_wide_go;
      rdata_q            <= next_rdata_q;
      done_q             <= next_done_q;
      bus_addr           <= next_addr;
      bus_data_out       <= next_dout;
      bus_data_oe        <= next_doe;
      high_byte_enable_n <= next_bhe_n;
      cycle_count        <= next_cycle_count;
    end
  end

  assign rsp.done            = done_q;
  assign rsp.rdata           = rdata_q;
  assign high_byte_enable_oe = pin_config.bhe_out_en;
  assign status_word = {cycle_count, 8'h00, 2'b00, wide_go, split,
                        odd_phase, state};

  // ----------------------------------------------------------------
  // strobes
  // ----------------------------------------------------------------
  cmd_s cmd;

  always_comb begin
    cmd.active    = (state == ST_CMD);
    cmd.is_io     = req_q.is_io;
    cmd.is_pccard = (req_q.target == TGT_PCCARD);
    cmd.write     = req_q.write;
  end

  strobe_router u_strobe (
    .pclk                 (pclk),
    .presetn              (presetn),
    .cmd                  (cmd),
    .cfg                  (pin_config),
    .slot_powered         (slot_powered),
    .mc_ram_active        (mc_ram_active),
    .mc_rom_read          (mc_rom_read),
    .rom_chip_enable_zero (rom_chip_enable_zero),
    .rom_chip_enable_one  (rom_chip_enable_one),
    .io_read_strobe_n     (io_read_strobe_n),
    .io_write_strobe_n    (io_write_strobe_n),
    .mem_read_strobe_n    (mem_read_strobe_n),
    .mem_write_strobe_n   (mem_write_strobe_n),
    .pccard_oe_n          (pccard_oe_n),
    .pccard_we_n          (pccard_we_n),
    .pccard_strobe_oe     (pccard_strobe_oe)
  );
endmodule // isa_expansion_cycle_control

// ===== tb/isa_exp_sva.sv
// assertions on the expansion cycle controller ports
// assumes: bound to isa_expansion_cycle_control, one clock domain
`timescale 1ns/100ps
module isa_exp_sva import isa_expansion_pkg::*; #(parameter int PADDR_W = 12) (
  // clock, apb, request side
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [31:0]        pwdata,
  input wire isa_req_s           req,
  input wire logic               req_ready,
  input wire isa_rsp_s           rsp,
  input wire logic               mc_ram_active,
  input wire logic               slot_powered,
  // pins
  input wire logic               io_read_strobe_n,
  input wire logic               io_write_strobe_n,
  input wire logic               mem_read_strobe_n,
  input wire logic               mem_write_strobe_n,
  input wire logic               pccard_strobe_oe,
  input wire logic               expansion_bus_clock
);
  // ----
  // mode shadow and idle count
  // ----
  logic [1:0] mode;
  logic [3:0] idle;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= 2'h0;
      idle <= 4'h0;
    end else begin
      if (psel && penable && pwrite && paddr == 12'h0D0) mode <= pwdata[7:6];
      idle <= (!req_ready || psel) ? 4'h0 : idle + {3'h0, idle != 4'hF};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ram; mc_ram_active |-> mem_read_strobe_n && mem_write_strobe_n; endproperty
  a_ram: assert property (p_ram) else $error("memory strobe during ram access");
  property p_one;
    $onehot0({~io_read_strobe_n, ~io_write_strobe_n, ~mem_read_strobe_n, ~mem_write_strobe_n});
  endproperty
  a_one: assert property (p_one) else $error("two strobes at once");
  property p_card; !slot_powered |=> !pccard_strobe_oe; endproperty
  a_card: assert property (p_card) else $error("card strobes driven unpowered");
  property p_stay; req_ready && req.valid && req.target == TGT_RAM |=> req_ready; endproperty
  a_stay: assert property (p_stay) else $error("ram access taken");
  property p_take; req_ready && req.valid && req.target == TGT_ISA |=> !req_ready; endproperty
  a_take: assert property (p_take) else $error("isa access not taken");
  property p_done; $fell(req_ready) |-> ##[4:400] rsp.done; endproperty
  a_done: assert property (p_done) else $error("cycle never finished");
  property p_stop; mode == 2'h0 && idle == 4'hF |-> $stable(expansion_bus_clock); endproperty
  a_stop: assert property (p_stop) else $error("bus clock runs idle in stop");
  property p_run;
    mode != 2'h0 && idle == 4'hF |-> ##[1:4] $changed(expansion_bus_clock);
  endproperty
  a_run: assert property (p_run) else $error("bus clock halted");
endmodule // isa_exp_sva
bind isa_expansion_cycle_control isa_exp_sva #(.PADDR_W(PADDR_W)) u_isa_exp_sva (.*);

// ===== tb/isa_peripheral_model.sv
// isa peripheral: small byte store, optional wide select, optional slow ready
// assumes: sees the controller's address, data and strobe pins
`timescale 1ns/100ps
module isa_peripheral_model (
  // from controller and bench
  input wire logic        pclk,
  input wire logic [19:0] bus_addr,
  input wire logic [15:0] bus_data_out,
  input wire logic        high_byte_enable_n,
  input wire logic        io_read_strobe_n,
  input wire logic        io_write_strobe_n,
  input wire logic        mem_read_strobe_n,
  input wire logic        mem_write_strobe_n,
  input wire logic        wide_cap,
  input wire logic        slow,
  // toward controller
  output logic [15:0]     bus_data_in,
  output logic            channel_ready,
  output logic            io_wide_select_n,
  output logic            mem_wide_select_n
);
  logic [7:0]  mem [16];
  logic [15:0] pat = 16'h0000;
  logic [1:0]  hold = 2'h0;
  logic [3:0]  a;
  logic        rd;
  logic        wr;
  assign a = bus_addr[3:0];
  assign rd = !io_read_strobe_n || !mem_read_strobe_n;
  assign wr = !io_write_strobe_n || !mem_write_strobe_n;
  assign io_wide_select_n = !wide_cap;
  assign mem_wide_select_n = !wide_cap;
  assign channel_ready = (hold == 2'h0);
  // released lines wander so a stale byte cannot pass as read data
  assign bus_data_in = rd ? {mem[a | 4'h1], mem[a]} : pat;
  always @(posedge pclk) begin
    pat <= pat + 16'h3A5B;
    hold <= (rd || wr) ? hold - {1'b0, hold != 2'h0} : {slow, slow};
    if (wr) begin
      mem[a] <= bus_data_out[7:0];
      if (!high_byte_enable_n && !a[0]) mem[a | 4'h1] <= bus_data_out[15:8];
    end
  end
endmodule // isa_peripheral_model

// ===== tb/tb_top.sv
// random and corner tests of the expansion cycle controller
// assumes: peripheral model on the bus pins, apb master here
`timescale 1ns/100ps
module tb_top import isa_expansion_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req_ready, e, wide_cap, slow;
  logic mc_ram_active, mc_rom_read, rom_chip_enable_zero, rom_chip_enable_one, slot_powered;
  logic io_read_strobe_n, io_write_strobe_n, mem_read_strobe_n, mem_write_strobe_n;
  logic high_byte_enable_n, high_byte_enable_oe, expansion_bus_clock, bus_clock_gpio_oe;
  logic pccard_oe_n, pccard_we_n, pccard_strobe_oe, bus_data_oe, channel_ready;
  logic io_wide_select_n, mem_wide_select_n;
  logic [1:0]  oscillator_divider_select;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, p, c;
  logic [19:0] bus_addr, a;
  logic [15:0] bus_data_out, bus_data_in, d;
  isa_req_s    req;
  isa_rsp_s    rsp;
  int          num_errors, n_checks;
  isa_expansion_cycle_control u_isa_expansion_cycle_control (.*);
  isa_peripheral_model u_isa_peripheral_model (.*);
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic xfer(input target_e t, input logic io, input logic w);
    @(posedge pclk);
    req <= '{1'b1, t, io, w, 1'b1, a, d};
    @(negedge pclk);
    while (req_ready !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    req.valid <= 1'b0;
    @(negedge pclk);
    while (rsp.done !== 1'b1) @(negedge pclk);
    q = {16'h0000, rsp.rdata};
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // watchdog, well beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_of_test;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, req, wide_cap, slow} = '0;
    {mc_ram_active, mc_rom_read, rom_chip_enable_zero, rom_chip_enable_one, slot_powered} = '0;
    {num_errors, n_checks} = '0;
    void'($urandom(56));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("osc_sel", 32'h1, {30'h0, oscillator_divider_select});
    apb(1'b0, 12'h004, 32'h0);
    chk("clock_generator_mode", 32'h22, q);
    apb(1'b0, 12'h0D0, 32'h0);
    chk("expansion_bus_mode", 32'h0, q);
    apb(1'b0, 12'h200, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    // ram access must stay pending with the memory controller
    mc_ram_active <= 1'b1;
    req <= '{1'b1, TGT_RAM, 1'b0, 1'b0, 1'b1, 20'h00010, 16'h0000};
    repeat (6) @(negedge pclk);
    chk("ram_ready", 32'h1, {31'h0, req_ready});
    @(posedge pclk);
    {req.valid, mc_ram_active} <= 2'b00;
    for (int i = 0; i < 9; i++) begin
      p = $urandom;
      apb(1'b1, 12'h0D0, {24'h0, 2'(i / 3), 6'h0});
      c = {25'h0, p[6:5], 3'h0, 2'(i % 3)};
      apb(1'b1, 12'h004, c);
      apb(1'b0, 12'h004, 32'h0);
      chk("clock_generator_mode", c, q);
      chk("osc_sel", {30'h0, p[6:5]}, {30'h0, oscillator_divider_select});
      apb(1'b1, 12'h100, {26'h0, p[13:8]});
      {wide_cap, slow, slot_powered} <= p[18:16];
      repeat (20) @(posedge pclk);
      chk("card_oe", {31'h0, p[12] & p[16]}, {31'h0, pccard_strobe_oe});
      chk("gpio_oe", {30'h0, p[11:10]},
          {30'h0, bus_clock_gpio_oe, high_byte_enable_oe});
      for (int k = 0; k < 3; k++) begin
        a = {16'h0, 3'($urandom), 1'b0};
        d = 16'($urandom);
        xfer(TGT_ISA, k[0], 1'b1);
        xfer(TGT_ISA, k[0], 1'b0);
        chk("rdata", {16'h0, d}, q);
      end
    end
    end_of_test;
  end
endmodule // tb_top
